// *** hdl/tone_modem_dev.sv ***
// device end: automodem link report, main status flags and tone table loader
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module tone_modem_dev
  import tone_pkg::*;
#(
  parameter logic [PROC_CNT_W-1:0] PROC_CYCLES_P = PROC_CYCLES[PROC_CNT_W-1:0]
) (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               srst,
  // register port
  tone_bus_if.dev                 bus,
  // modem core side
  input  wire logic               powersave,
  input  wire logic               msg_stb,
  input  wire logic [5:0]         msg_code,
  input  wire snr_t               snr_in,
  input  wire logic               connected,
  input  wire logic [2:0]         mode_in,
  // transmit tone generator side
  output logic [15:0]             tone_word [TABLE_WORDS],
  output logic [TONES-1:0]        tone_on,
  output logic [PAIRS-1:0]        pair_on,
  output logic                    prog_flag,
  output logic                    report_chg
);
  // ****************************************************************
  // link report
  // ****************************************************************
  logic [5:0]  msg_q;
  logic [6:0]  snr_mode_q;
  logic [6:0]  snr_mode_d;
  logic [2:0]  snr_code;
  logic [2:0]  mode_code;
  logic        chg_q;
  logic        chg_set;
  logic [15:0] report_word;

  // unused snr code reads as "not yet determined"
  assign snr_code   = (snr_in == SNR_UNUSED) ? SNR_UNKNOWN : snr_in;
  // idle-group codes above training are unused; shown as idle
  assign mode_code  = connected ? mode_in
                    : (mode_in > LINK_TRAINING) ? LINK_IDLE : mode_in;
  assign snr_mode_d = {snr_code, 1'b0, mode_code};
  assign chg_set    = msg_stb || (snr_mode_d != snr_mode_q);
  assign report_word = {msg_q, 3'h0, snr_mode_q};

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      msg_q      <= 6'h00;
      snr_mode_q <= 7'h00;
    end else begin
      if (msg_stb) begin
        msg_q <= msg_code;
      end
      snr_mode_q <= snr_mode_d;
    end
  end

  // ****************************************************************
  // register decode
  // ****************************************************************
  logic        wr_load;
  logic        rd_main;
  logic        rd_report;
  logic [15:0] rdata_d;
  logic        flag_q;
  logic [15:0] main_word;

  // writes while the flag is low are dropped, the host must poll first
  assign wr_load   = bus.wr_stb && (bus.addr == ADDR_TONE_LOAD) && flag_q;
  assign rd_main   = bus.rd_stb && (bus.addr == ADDR_MAIN_STATUS);
  assign rd_report = bus.rd_stb && (bus.addr == ADDR_LINK_REPORT);
  always_comb begin
    main_word                      = 16'h0000;
    main_word[MAIN_PROG_FLAG_BIT]  = flag_q;
    main_word[MAIN_REPORT_CHG_BIT] = chg_q;
  end
  assign rdata_d = rd_main   ? main_word
                 : rd_report ? report_word : 16'h0000;

  // change bit is sticky until the main status is read; a new change wins
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      chg_q     <= 1'b0;
      bus.rdata <= 16'h0000;
    end else begin
      chg_q     <= chg_set || (chg_q && !rd_main);
      bus.rdata <= rdata_d;
    end
  end

  // ****************************************************************
  // programming handshake
  // ****************************************************************
  logic [PROC_CNT_W-1:0] proc_cnt_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      flag_q     <= 1'b1;
      proc_cnt_q <= '0;
    end else if (wr_load) begin
      flag_q     <= 1'b0;
      proc_cnt_q <= PROC_CYCLES_P - 1'b1;
    end else if (!flag_q) begin
      if (proc_cnt_q == '0) begin
        flag_q <= 1'b1;
      end
      proc_cnt_q <= proc_cnt_q - 1'b1;
    end
  end

  // ****************************************************************
  // word sequencer and tone table
  // ****************************************************************
  logic [4:0] word_cnt_q;
  logic       rx_load_q;
  logic       is_hdr_tx;
  logic       is_hdr_rx;
  logic       store;
  logic [3:0] store_idx;

  assign is_hdr_tx = (bus.wdata == HDR_TX);
  assign is_hdr_rx = (bus.wdata == HDR_RX);
  // words outside the value range or past the end are ignored
  assign store     = wr_load && !is_hdr_tx && !is_hdr_rx && !rx_load_q
                   && (word_cnt_q != 5'h00) && (word_cnt_q < 5'(TX_WORDS))
                   && (bus.wdata <= WORD_MAX);
  assign store_idx = 4'(word_cnt_q - 5'h01);

  always_ff @(posedge sys_clk) begin
    if (srst || powersave) begin
      word_cnt_q <= 5'h00;
      rx_load_q  <= 1'b0;
    end else if (wr_load) begin
      if (is_hdr_tx || is_hdr_rx) begin
        word_cnt_q <= 5'h01;
        rx_load_q  <= is_hdr_rx;
      end else if (word_cnt_q != 5'h00 && word_cnt_q < 5'(RX_WORDS)) begin
        // the receive detector coefficients go to the detector core, not here
        word_cnt_q <= word_cnt_q + 5'h01;
      end
    end
  end

  // reset and powersave restore the power-up table
  always_ff @(posedge sys_clk) begin
    if (srst || powersave) begin
      for (int i = 0; i < TABLE_WORDS; i++) begin
        tone_word[i] <= 16'h0000;
      end
      tone_word[12] <= RST_FREQ_A;
      tone_word[13] <= RST_LEVEL;
      tone_word[14] <= RST_FREQ_B;
      tone_word[15] <= RST_LEVEL;
    end else if (store) begin
      tone_word[store_idx] <= bus.wdata;
    end
  end

  // ****************************************************************
  // tone enables
  // ****************************************************************
  logic [TONES-1:0] tone_on_d;
  logic [PAIRS-1:0] pair_on_d;

  always_comb begin
    for (int t = 0; t < TONES; t++) begin
      tone_on_d[t] = (tone_word[2*t] != 16'h0000)
                  || (tone_word[2*t+1] != 16'h0000);
    end
    for (int p = 0; p < PAIRS; p++) begin
      pair_on_d[p] = tone_on_d[2*p] || tone_on_d[2*p+1];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tone_on    <= '0;
      pair_on    <= '0;
      prog_flag  <= 1'b1;
      report_chg <= 1'b0;
    end else begin
      tone_on    <= tone_on_d;
      pair_on    <= pair_on_d;
      prog_flag  <= flag_q;
      report_chg <= chg_q;
    end
  end
endmodule : tone_modem_dev

// *** hdl/tone_pkg.sv ***
// constants and types shared by the tone-table device and its host controller
package tone_pkg;
  // ****************************************************************
  // bus map
  // ****************************************************************
  localparam int unsigned ADDR_W             = 8;
  localparam int unsigned DATA_W             = 16;
  localparam logic [7:0]  ADDR_TONE_LOAD     = 8'hE8;
  localparam logic [7:0]  ADDR_LINK_REPORT   = 8'hEB;
  localparam logic [7:0]  ADDR_MAIN_STATUS   = 8'hE6;
  localparam int unsigned MAIN_PROG_FLAG_BIT = 13;
  localparam int unsigned MAIN_REPORT_CHG_BIT = 9;
  localparam int unsigned REP_MSG_LSB        = 10;
  localparam int unsigned REP_SNR_LSB        = 4;
  localparam int unsigned REP_MODE_LSB       = 0;
  // ****************************************************************
  // load sequence
  // ****************************************************************
  localparam logic [15:0] HDR_TX      = 16'h8000;
  localparam logic [15:0] HDR_RX      = 16'h8001;
  localparam logic [15:0] WORD_MAX    = 16'h3FFF;
  localparam int unsigned TX_WORDS    = 17;
  localparam int unsigned RX_WORDS    = 27;
  localparam int unsigned PAIRS       = 4;
  localparam int unsigned TABLE_WORDS = 16;
  localparam int unsigned TONES       = 8;
  // ****************************************************************
  // reset table: pair four = 2130 Hz + 2750 Hz at about 100 mVrms
  // ****************************************************************
  localparam logic [15:0] RST_FREQ_A  = 16'h1C68;
  localparam logic [15:0] RST_FREQ_B  = 16'h24AD;
  localparam logic [15:0] RST_LEVEL   = 16'h0B1A;
  // ****************************************************************
  // encoding and timing
  // ****************************************************************
  localparam int unsigned FREQ_SCALE_MILLI = 3414;
  localparam int unsigned LEVEL_SCALE      = 93780;
  localparam int unsigned SUPPLY_MV_DFLT   = 3300;
  localparam int unsigned CLK_PERIOD_NS    = 8;
  localparam int unsigned PROC_TIME_US     = 150;
  localparam int unsigned PROC_CYCLES      = PROC_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned PROC_CNT_W       = 15;
  // ****************************************************************
  // report codes
  // ****************************************************************
  typedef enum logic [2:0] {
    SNR_VERY_GOOD = 3'h7, SNR_GOOD = 3'h6, SNR_NORMAL = 3'h5, SNR_POOR = 3'h4,
    SNR_BAD = 3'h3, SNR_REALLY_BAD = 3'h2, SNR_UNUSED = 3'h1, SNR_UNKNOWN = 3'h0
  } snr_t;
  typedef enum logic [2:0] {
    RATE_14400 = 3'h7, RATE_12000 = 3'h6, RATE_9600_TCM = 3'h5, RATE_9600 = 3'h4,
    RATE_7200 = 3'h3, RATE_4800 = 3'h2, RATE_2400 = 3'h1, RATE_1200 = 3'h0
  } rate_t;
  typedef enum logic [2:0] {
    LINK_TRAINING = 3'h4, LINK_ANSWER_TONE = 3'h3, LINK_TX_SILENT = 3'h2,
    LINK_RX_WAIT = 3'h1, LINK_IDLE = 3'h0
  } link_state_t;
endpackage : tone_pkg

// *** hdl/tone_bus_if.sv ***
// register port between the host controller and the tone-table device
`timescale 1ns/1ps
interface tone_bus_if (
  input wire logic sys_clk
);
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr_stb;
  logic        rd_stb;
  logic [15:0] rdata;

  modport dev  (input addr, wdata, wr_stb, rd_stb, output rdata);
  modport host (output addr, wdata, wr_stb, rd_stb, input rdata);
endinterface : tone_bus_if

// *** hdl/tone_modem_host.sv ***
// host end: loads the transmit tone table and fetches the link report
`timescale 1ns/1ps
module tone_modem_host
  import tone_pkg::*;
#(
  parameter int unsigned SUPPLY_MV = SUPPLY_MV_DFLT
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // register port
  tone_bus_if.host         bus,
  // user side
  input  wire logic        load_start,
  input  wire logic [11:0] freq_hz [TONES],
  input  wire logic [11:0] level_mv [TONES],
  input  wire logic        report_req,
  output logic             busy,
  output logic             load_done,
  output logic [15:0]      report,
  output logic             report_valid
);
  typedef enum logic [7:0] {
    S_IDLE   = 8'b00000001,
    S_POLL   = 8'b00000010,
    S_PWAIT  = 8'b00000100,
    S_CHECK  = 8'b00001000,
    S_WRITE  = 8'b00010000,
    S_RDREP  = 8'b00100000,
    S_RWAIT  = 8'b01000000,
    S_GETREP = 8'b10000000
  } host_state_t;

  // ****************************************************************
  // word encoding, clipped into the legal value range
  // ****************************************************************
  function automatic logic [15:0] clip(input logic [31:0] v);
    clip = (v > 32'(WORD_MAX)) ? WORD_MAX : v[15:0];
  endfunction : clip

  host_state_t state_q;
  logic        report_job_q;
  logic [4:0]  idx_q;
  logic [11:0] freq_q [TONES];
  logic [11:0] level_q [TONES];
  logic [3:0]  slot;
  logic [2:0]  tone_sel;
  logic [31:0] freq_val;
  logic [31:0] level_val;
  logic [15:0] word;
  logic        flag_seen;

  assign slot      = 4'(idx_q - 5'h01);
  assign tone_sel  = {slot[3:2], slot[1]};
  assign freq_val  = 32'(freq_q[tone_sel]) * FREQ_SCALE_MILLI / 1000;
  assign level_val = 32'(level_q[tone_sel]) * LEVEL_SCALE / SUPPLY_MV;
  assign word      = (idx_q == 5'h00) ? HDR_TX
                   : slot[0] ? clip(level_val) : clip(freq_val);
  assign flag_seen = bus.rdata[MAIN_PROG_FLAG_BIT];

  // ****************************************************************
  // sequencer: every load write and report read waits for the programming flag
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q      <= S_IDLE;
      report_job_q <= 1'b0;
      idx_q        <= 5'h00;
      bus.addr     <= 8'h00;
      bus.wdata    <= 16'h0000;
      bus.wr_stb   <= 1'b0;
      bus.rd_stb   <= 1'b0;
      busy         <= 1'b0;
      load_done    <= 1'b0;
      report       <= 16'h0000;
      report_valid <= 1'b0;
    end else begin
      bus.wr_stb   <= 1'b0;
      bus.rd_stb   <= 1'b0;
      load_done    <= 1'b0;
      report_valid <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (load_start || report_req) begin
            report_job_q <= !load_start;
            idx_q        <= 5'h00;
            freq_q       <= freq_hz;
            level_q      <= level_mv;
            busy         <= 1'b1;
            state_q      <= S_POLL;
          end
        end
        S_POLL: begin
          bus.addr   <= ADDR_MAIN_STATUS;
          bus.rd_stb <= 1'b1;
          state_q    <= S_PWAIT;
        end
        // the slave registers its read data on the strobe edge; look one cycle later
        S_PWAIT: begin
          state_q <= S_CHECK;
        end
        S_CHECK: begin
          // read data stands now; poll the main status again until the flag is back
          if (!flag_seen) begin
            state_q <= S_POLL;
          end else if (report_job_q) begin
            state_q <= S_RDREP;
          end else begin
            state_q <= S_WRITE;
          end
        end
        S_WRITE: begin
          bus.addr   <= ADDR_TONE_LOAD;
          bus.wdata  <= word;
          bus.wr_stb <= 1'b1;
          idx_q      <= idx_q + 5'h01;
          if (idx_q == 5'(TX_WORDS - 1)) begin
            busy      <= 1'b0;
            load_done <= 1'b1;
            state_q   <= S_IDLE;
          end else begin
            state_q <= S_POLL;
          end
        end
        S_RDREP: begin
          bus.addr   <= ADDR_LINK_REPORT;
          bus.rd_stb <= 1'b1;
          state_q    <= S_RWAIT;
        end
        S_RWAIT: begin
          state_q <= S_GETREP;
        end
        S_GETREP: begin
          report       <= bus.rdata;
          report_valid <= 1'b1;
          busy         <= 1'b0;
          state_q      <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule : tone_modem_host

// *** tb/tone_modem_monitor.sv ***
// checker watching the register port between the host end and the device end
`timescale 1ns/1ps
module tone_modem_monitor
  import tone_pkg::*;
#(
  parameter int PROC = 18750
) (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        srst,
  // register port
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [15:0] rdata
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ****************************************************************
  // helper state
  // ****************************************************************
  logic [15:0] cnt_q;
  logic [4:0]  wcnt_q;
  logic        poll_q;
  logic        ok_q;
  wire         wr_load = wr_stb && (addr == ADDR_TONE_LOAD);
  wire         rd_main = rd_stb && (addr == ADDR_MAIN_STATUS);
  wire         rd_rep  = rd_stb && (addr == ADDR_LINK_REPORT);
  // a flag seen high stays usable until the next load write consumes it
  wire         flag_ok = ok_q || (poll_q && rdata[MAIN_PROG_FLAG_BIT]);
  wire         cnt_sat = (cnt_q == 16'hFFFF);
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_q  <= 16'hFFFF;
      wcnt_q <= 5'h00;
      poll_q <= 1'b0;
      ok_q   <= 1'b0;
    end else begin
      cnt_q  <= wr_load ? 16'h0001 : cnt_q + {15'h0000, !cnt_sat};
      wcnt_q <= !wr_load ? wcnt_q : (wcnt_q == 5'h10) ? 5'h00 : wcnt_q + 5'h01;
      poll_q <= rd_main;
      ok_q   <= !wr_load && flag_ok;
    end
  end
  // ****************************************************************
  // assertions
  // ****************************************************************
  hdr_first_a: assert property (wr_load && wcnt_q == 5'h00 |-> wdata == HDR_TX)
    else $error("load sequence does not open with the header");
  data_range_a: assert property (wr_load && wcnt_q != 5'h00 |-> wdata <= WORD_MAX)
    else $error("load data word out of range");
  write_gated_a: assert property (wr_load |-> flag_ok)
    else $error("load write without the flag seen high");
  any_write_a: assert property (wr_stb |-> flag_ok)
    else $error("register write while a word is processed");
  report_gated_a: assert property (rd_rep |-> flag_ok)
    else $error("report read without the flag seen high");
  flag_drop_a: assert property (rd_main && cnt_q >= 1 && cnt_q < PROC |=> !rdata[13])
    else $error("flag high while a word is processed");
  flag_back_a: assert property (rd_main && cnt_q > PROC + 1 |=> rdata[13])
    else $error("flag late to return");
  status_bits_a: assert property (rd_main |=> (rdata & ~16'h2200) == 16'h0000)
    else $error("main status shows stray bits");
  zero_gap_a: assert property (rd_rep |=> rdata[9:7] == 3'h0)
    else $error("report bits 9..7 not zero");
  snr_code_a: assert property (rd_rep |=> rdata[6:4] != 3'h1)
    else $error("unused snr code reported");
endmodule : tone_modem_monitor

// *** tb/tb_modem_status_and_tone_programming.sv ***
// testbench: host and device joined, plus a second device driven directly
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end
module tb_modem_status_and_tone_programming
  import tone_pkg::*;
;
  logic        sys_clk, srst, powersave, msg_stb, connected, load_start, report_req;
  logic [5:0]  msg_code;
  logic [2:0]  snr_v, mode_in;
  logic [11:0] freq_hz [TONES];
  logic [11:0] level_mv [TONES];
  logic [15:0] tw [TABLE_WORDS];
  logic [15:0] tw2 [TABLE_WORDS];
  logic [15:0] exp_w [TABLE_WORDS];
  logic [15:0] report, d;
  logic [7:0]  ton, ton2;
  logic [3:0]  pon, pon2;
  logic        busy, load_done, report_valid, chg2, flag2;
  int          fails, num_checks, cyc;
  tone_bus_if bus (.sys_clk(sys_clk));
  tone_bus_if bus2 (.sys_clk(sys_clk));
  tone_modem_dev #(.PROC_CYCLES_P(15'h0014)) u_tone_modem_dev (.sys_clk(sys_clk), .srst(srst),
    .bus(bus), .powersave(powersave), .msg_stb(msg_stb), .msg_code(msg_code),
    .snr_in(snr_t'(snr_v)), .connected(connected), .mode_in(mode_in), .tone_word(tw),
    .tone_on(ton), .pair_on(pon), .prog_flag(), .report_chg());
  tone_modem_dev #(.PROC_CYCLES_P(15'h0014)) u_tone_modem_dev_2 (.sys_clk(sys_clk), .srst(srst),
    .bus(bus2), .powersave(powersave), .msg_stb(msg_stb), .msg_code(msg_code),
    .snr_in(snr_t'(snr_v)), .connected(connected), .mode_in(mode_in), .tone_word(tw2),
    .tone_on(ton2), .pair_on(pon2), .prog_flag(flag2), .report_chg(chg2));
  tone_modem_host u_tone_modem_host (.sys_clk(sys_clk), .srst(srst), .bus(bus),
    .load_start(load_start), .freq_hz(freq_hz), .level_mv(level_mv), .report_req(report_req),
    .busy(busy), .load_done(load_done), .report(report), .report_valid(report_valid));
  tone_modem_monitor #(.PROC(20)) u_tone_modem_monitor (.sys_clk(sys_clk), .srst(srst),
    .addr(bus.addr), .wdata(bus.wdata), .wr_stb(bus.wr_stb), .rd_stb(bus.rd_stb),
    .rdata(bus.rdata));
  // ****************************************************************
  // clock, timeout and closing
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  // the whole run needs well under 10000 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  // ****************************************************************
  // expectations and bus tasks
  // ****************************************************************
  function automatic logic [15:0] clip(input int v);
    return (v > 16383) ? WORD_MAX : v[15:0];
  endfunction : clip
  function automatic logic [15:0] exp_report(input logic [5:0] m, input logic [2:0] s,
                                             input logic c, input logic [2:0] md);
    logic [2:0] se;
    logic [2:0] me;
    se = (s == 3'h1) ? 3'h0 : s;
    me = (!c && md > 3'h4) ? 3'h0 : md;
    return {m, 3'h0, se, 1'b0, me};
  endfunction : exp_report
  task automatic dflt();
    foreach (exp_w[i]) exp_w[i] = 16'h0000;
    exp_w[12] = clip((2130 * 3414 + 500) / 1000);
    exp_w[14] = clip((2750 * 3414 + 500) / 1000);
    exp_w[13] = clip((100 * 93780 + 1650) / 3300);
    exp_w[15] = exp_w[13];
  endtask : dflt
  task automatic cmp_tab(input logic [15:0] g [TABLE_WORDS], input logic [7:0] gon,
                         input logic [3:0] gpon);
    logic [7:0] e;
    // settle past the clock edge before looking at registered outputs
    #1;
    for (int t = 0; t < TONES; t++) e[t] = (exp_w[2*t] != 0) || (exp_w[2*t+1] != 0);
    for (int i = 0; i < TABLE_WORDS; i++) `CHK(g[i], exp_w[i])
    `CHK(gon, e)
    `CHK(gpon, {e[7] | e[6], e[5] | e[4], e[3] | e[2], e[1] | e[0]})
  endtask : cmp_tab
  task automatic wait_hi(ref logic s);
    for (int n = 0; n < 3000; n++) begin
      @(posedge sys_clk);
      #1;
      if (s === 1'b1) return;
    end
    fails++;
    $display("unexpected at %0t: no handshake", $time);
  endtask : wait_hi
  task automatic wr2(input logic [7:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    bus2.addr   <= a;
    bus2.wdata  <= v;
    bus2.wr_stb <= 1'b1;
    @(posedge sys_clk);
    bus2.wr_stb <= 1'b0;
  endtask : wr2
  task automatic rd2(input logic [7:0] a, output logic [15:0] v);
    @(posedge sys_clk);
    bus2.addr   <= a;
    bus2.rd_stb <= 1'b1;
    @(posedge sys_clk);
    bus2.rd_stb <= 1'b0;
    #1 v = bus2.rdata;
  endtask : rd2
  // polls the flag before each load word, as the host must
  task automatic put2(input logic [15:0] v);
    logic [15:0] s;
    for (int n = 0; n < 100; n++) begin
      rd2(ADDR_MAIN_STATUS, s);
      if (s[13] === 1'b1) break;
    end
    wr2(ADDR_TONE_LOAD, v);
  endtask : put2
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {srst, powersave, msg_stb, connected, load_start, report_req} = 6'h20;
    {msg_code, snr_v, mode_in} = 12'h000;
    {bus2.addr, bus2.wdata, bus2.wr_stb, bus2.rd_stb} = 26'h0000000;
    foreach (freq_hz[t]) {freq_hz[t], level_mv[t]} = 24'h000000;
    void'($urandom(32'h84B711CB));
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    dflt();
    cmp_tab(tw, ton, pon);
    $display("reset table test done");
    for (int n = 0; n < 4; n++) begin
      for (int t = 0; t < TONES; t++) begin
        freq_hz[t]  <= ((n == 1 && t / 2 == 1) || (n == 2 && t == 0)) ? 12'h000 :
                       12'($urandom_range(3400));
        level_mv[t] <= ((n == 1 && t / 2 == 1) || (n == 2 && t == 0)) ? 12'h000 :
                       (n == 3 && t == 7) ? 12'hFFF : 12'($urandom_range(700));
      end
      @(posedge sys_clk);
      load_start <= 1'b1;
      @(posedge sys_clk);
      load_start <= 1'b0;
      #1 `CHK(busy, 1'b1)
      wait_hi(load_done);
      `CHK(busy, 1'b0)
      repeat (3) @(posedge sys_clk);
      for (int t = 0; t < TONES; t++) begin
        exp_w[2*t]   = clip(int'(freq_hz[t]) * 3414 / 1000);
        exp_w[2*t+1] = clip(int'(level_mv[t]) * 93780 / 3300);
      end
      cmp_tab(tw, ton, pon);
    end
    $display("host load test done");
    for (int i = 0; i < 16; i++) begin
      // a main status read clears the change bit, so each message must set it anew
      rd2(ADDR_MAIN_STATUS, d);
      repeat (2) @(posedge sys_clk);
      #1 `CHK(chg2, 1'b0)
      @(posedge sys_clk);
      connected <= i[3];
      mode_in   <= i[2:0];
      snr_v     <= 3'(i * 3);
      msg_code  <= 6'($urandom);
      msg_stb   <= 1'b1;
      @(posedge sys_clk);
      msg_stb <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1 `CHK(chg2, 1'b1)
      @(posedge sys_clk);
      report_req <= 1'b1;
      @(posedge sys_clk);
      report_req <= 1'b0;
      wait_hi(report_valid);
      `CHK(report, exp_report(msg_code, snr_v, connected, mode_in))
    end
    $display("report test done");
    rd2(ADDR_MAIN_STATUS, d);
    `CHK(d[13], 1'b1)
    `CHK(flag2, 1'b1)
    rd2(ADDR_TONE_LOAD, d);
    `CHK(d, 16'h0000)
    rd2(8'h00, d);
    `CHK(d, 16'h0000)
    wr2(ADDR_TONE_LOAD, HDR_TX);
    rd2(ADDR_MAIN_STATUS, d);
    `CHK(d[13], 1'b0)
    `CHK(flag2, 1'b0)
    wr2(ADDR_TONE_LOAD, 16'h1234);
    dflt();
    for (int k = 0; k < 4; k++) begin
      exp_w[k] = 16'($urandom_range(16383));
      put2(exp_w[k]);
    end
    put2(16'h7FFF);
    repeat (3) @(posedge sys_clk);
    cmp_tab(tw2, ton2, pon2);
    put2(HDR_TX);
    put2(16'h0005);
    exp_w[0] = 16'h0005;
    repeat (3) @(posedge sys_clk);
    cmp_tab(tw2, ton2, pon2);
    // a receive load is counted but must leave the transmit table alone
    put2(HDR_RX);
    put2(16'h0123);
    repeat (3) @(posedge sys_clk);
    cmp_tab(tw2, ton2, pon2);
    @(posedge sys_clk);
    powersave <= 1'b1;
    @(posedge sys_clk);
    powersave <= 1'b0;
    repeat (3) @(posedge sys_clk);
    dflt();
    cmp_tab(tw2, ton2, pon2);
    cmp_tab(tw, ton, pon);
    $display("direct port test done");
    finish_test();
  end
endmodule : tb_modem_status_and_tone_programming
